// ---- common/ddr_turn_pkg.sv ----
// Shared constants for the data-pin turnaround link
package ddr_turn_pkg;
    // ******************************
    // Pin states and timing
    // ******************************
    typedef enum {
        pin_term,
        pin_low,
        pin_read,
        pin_undef
    } pin_state_e;
    localparam int unsigned READ_LATENCY     = 3;
    localparam int unsigned MIN_IDLE_AFTER_W = 0;
    localparam int unsigned MIN_IDLE_BEFORE_R = 0;
    localparam int unsigned MIN_RIDLE_AFTER_R = 2;
    localparam int unsigned MIN_WIDLE_BEFORE_W = 3;
    localparam int unsigned TYP_RIDLE_BEFORE_R = 2;
    localparam int unsigned TYP_RIDLE_AFTER_R = 4;
    localparam int unsigned TYP_WIDLE_BEFORE_W = 5;
    localparam int unsigned CLK_DIV_HALF     = 1;
    localparam logic [1:0]  RESET_CMD        = 2'h3;
endpackage : ddr_turn_pkg

// ---- common/ddr_turn_if.sv ----
// Link between controller and memory data-pin end
`timescale 1ns/10ps
interface ddr_turn_if #(parameter int DATA_W = 18);
    logic              link_clk;
    logic              load_select_n;
    logic              rw_select;
    logic [DATA_W-1:0] ctl_dq_out;
    logic              ctl_dq_oe_n;
    logic              ctl_term_en;
    logic [DATA_W-1:0] mem_dq_out;
    logic              mem_dq_oe_n;
    logic              mem_term_en;
    logic [DATA_W-1:0] dq_in;
    modport mem (input link_clk, load_select_n, rw_select, dq_in,
                 output mem_dq_out, mem_dq_oe_n, mem_term_en);
    modport ctl (output link_clk, load_select_n, rw_select, ctl_dq_out, ctl_dq_oe_n, ctl_term_en,
                 input dq_in);
endinterface : ddr_turn_if

// ---- hdl/ddr_mem_end.sv ----
// Memory-side data-pin turnaround end
`timescale 1ns/10ps
module ddr_mem_end #(
    parameter int DATA_W = 18
) (
    ddr_turn_if.mem                link,
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [DATA_W-1:0] rd_data,
    output logic [DATA_W-1:0]      wr_data,
    output logic                   wr_strobe,
    output logic                   rd_request
);
    initial begin
        if (DATA_W < 1) begin
            $error("DATA_W must be positive");
        end
        if (ddr_turn_pkg::READ_LATENCY < 2) begin
            $error("READ_LATENCY must be at least two");
        end
    end

    // ******************************
    // Command decode (link domain)
    // ******************************
    logic [ddr_turn_pkg::READ_LATENCY-1:0] rd_pipe;
    logic [ddr_turn_pkg::READ_LATENCY-1:0] rw_pipe;
    logic [ddr_turn_pkg::READ_LATENCY-1:0] wr_pipe;
    logic                                   read_sync1;
    logic                                   read_sync2;
    logic                                   read_sync3;
    logic                                   wr_tog;
    logic                                   rd_tog;
    logic [DATA_W-1:0]                      wr_hold;
    logic                                   wsync1;
    logic                                   wsync2;
    logic                                   wsync3;
    ddr_turn_pkg::pin_state_e               state;

    wire is_read  = !link.load_select_n && link.rw_select;
    wire is_write = !link.load_select_n && !link.rw_select;

    wire prev_read = rd_pipe[0];
    // next select decides n+3
    // Select of the command one cycle after the one two cycles back
    wire rw_now    = rw_pipe[0];

    ddr_turn_pkg::pin_state_e next_state;
    always_comb begin
        if (rd_pipe[1] && rw_now) begin
            next_state = ddr_turn_pkg::pin_read;
        end else if (rd_pipe[1]) begin
            next_state = ddr_turn_pkg::pin_undef;
        end else if (rw_now) begin
            next_state = ddr_turn_pkg::pin_low;
        end else begin
            next_state = ddr_turn_pkg::pin_term;
        end
    end

    always_ff @(posedge link.link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pipe <= '0;
            rw_pipe <= '1;
            wr_pipe <= '0;
            state   <= ddr_turn_pkg::pin_low;
        end else begin
            rd_pipe <= {rd_pipe[ddr_turn_pkg::READ_LATENCY-2:0], is_read};
            rw_pipe <= {rw_pipe[ddr_turn_pkg::READ_LATENCY-2:0], link.rw_select};
            wr_pipe <= {wr_pipe[ddr_turn_pkg::READ_LATENCY-2:0], is_write};
            // termination drops on next select high
            state   <= next_state;
        end
    end

    // ******************************
    // Pin drive (link domain)
    // ******************************
    always_ff @(posedge link.link_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.mem_dq_out  <= '0;
            link.mem_dq_oe_n <= 1'b0;
            link.mem_term_en <= 1'b0;
        end else begin
            link.mem_dq_out  <= (next_state == ddr_turn_pkg::pin_read) ? rd_data : '0;
            link.mem_dq_oe_n <= !(next_state == ddr_turn_pkg::pin_read || next_state == ddr_turn_pkg::pin_low);
            link.mem_term_en <= (next_state == ddr_turn_pkg::pin_term);
        end
    end

    // Write capture two cycles after command, toggle to ref domain
    always_ff @(posedge link.link_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_tog  <= 1'b0;
            wr_hold <= '0;
        end else if (wr_pipe[1] && state == ddr_turn_pkg::pin_term) begin
            wr_tog  <= !wr_tog;
            wr_hold <= link.dq_in;
        end
    end

    // One toggle per Read, so back-to-back reads each give a request
    always_ff @(posedge link.link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_tog <= 1'b0;
        end else if (is_read) begin
            rd_tog <= !rd_tog;
        end
    end

    // ******************************
    // Crossing to ref_clk
    // ******************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wsync1     <= 1'b0;
            wsync2     <= 1'b0;
            wsync3     <= 1'b0;
            read_sync1 <= 1'b0;
            read_sync2 <= 1'b0;
            read_sync3 <= 1'b0;
            wr_data    <= '0;
            wr_strobe  <= 1'b0;
            rd_request <= 1'b0;
        end else begin
            wsync1     <= wr_tog;
            wsync2     <= wsync1;
            wsync3     <= wsync2;
            read_sync1 <= rd_tog;
            read_sync2 <= read_sync1;
            read_sync3 <= read_sync2;
            wr_strobe  <= wsync2 ^ wsync3;
            rd_request <= read_sync2 ^ read_sync3;
            if (wsync2 ^ wsync3) begin
                wr_data <= wr_hold;
            end
        end
    end
endmodule : ddr_mem_end

// ---- hdl/ddr_ctl_end.sv ----
// Controller-side end: issues commands and drives write data
`timescale 1ns/10ps
module ddr_ctl_end #(
    parameter int DATA_W = 18
) (
    ddr_turn_if.ctl                link,
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [DATA_W-1:0] req_data,
    output logic                   req_ready,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   rd_valid
);
    initial begin
        if (DATA_W < 1) begin
            $error("DATA_W must be positive");
        end
    end

    // ******************************
    // Link clock divider and sequencer
    // ******************************
    logic [1:0] div_cnt;
    logic       last_read;
    logic       last_write;
    logic [2:0] ridle_cnt;
    logic [2:0] widle_cnt;
    logic [3:0] rd_pipe;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] wdata_d;
    logic [1:0] wr_pipe;

    // Commands change with the link clock's falling edge, half a cycle before the memory samples
    wire edge_now = (div_cnt == 2'h0);
    wire can_write = (ridle_cnt >= 3'(ddr_turn_pkg::TYP_RIDLE_AFTER_R)) || !last_read;
    wire wr_ready  = last_write || widle_cnt >= 3'(ddr_turn_pkg::TYP_WIDLE_BEFORE_W);
    // read idles before Read; none after Write
    wire rd_ready  = last_read || ridle_cnt >= 3'(ddr_turn_pkg::TYP_RIDLE_BEFORE_R);
    wire go_write  = req_valid && req_write && wr_ready;
    wire go_read   = req_valid && !req_write && rd_ready;
    wire want_w    = req_valid && req_write;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt            <= 2'h0;
            link.link_clk      <= 1'b0;
            link.load_select_n <= 1'b1;
            link.rw_select     <= 1'b1;
            last_read          <= 1'b0;
            last_write         <= 1'b0;
            ridle_cnt          <= 3'h7;
            widle_cnt          <= 3'h0;
            rd_pipe            <= 4'h0;
            wr_pipe            <= 2'h0;
            wdata_q            <= '0;
            wdata_d            <= '0;
            req_ready          <= 1'b0;
        end else begin
            div_cnt       <= div_cnt + 2'h1;
            link.link_clk <= div_cnt[1];
            req_ready     <= 1'b0;
            if (edge_now) begin
                rd_pipe <= {rd_pipe[2:0], 1'b0};
                wr_pipe <= {wr_pipe[0], 1'b0};
                wdata_d <= wdata_q;
                if (go_write && can_write) begin
                    link.load_select_n <= 1'b0;
                    link.rw_select     <= 1'b0;
                    last_write <= 1'b1;
                    last_read  <= 1'b0;
                    wr_pipe[0] <= 1'b1;
                    wdata_q    <= req_data;
                    req_ready  <= 1'b1;
                end else if (go_read) begin
                    link.load_select_n <= 1'b0;
                    link.rw_select     <= 1'b1;
                    last_read  <= 1'b1;
                    last_write <= 1'b0;
                    ridle_cnt  <= 3'h0;
                    rd_pipe[0] <= 1'b1;
                    req_ready  <= 1'b1;
                end else if (want_w && can_write) begin
                    // Write-side idle to turn the bus around
                    link.load_select_n <= 1'b1;
                    link.rw_select     <= 1'b0;
                    last_read  <= 1'b0;
                    if (widle_cnt != 3'h7) widle_cnt <= widle_cnt + 3'h1;
                end else begin
                    link.load_select_n <= 1'b1;
                    link.rw_select     <= 1'b1;
                    last_write <= 1'b0;
                    widle_cnt  <= 3'h0;
                    if (ridle_cnt != 3'h7) ridle_cnt <= ridle_cnt + 3'h1;
                end
            end
        end
    end

    // ******************************
    // Data pins
    // ******************************
    // drive low unless writing or receiving
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.ctl_dq_out  <= '0;
            link.ctl_dq_oe_n <= 1'b0;
            link.ctl_term_en <= 1'b0;
            rd_data          <= '0;
            rd_valid         <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (edge_now) begin
                link.ctl_term_en <= rd_pipe[1] || rd_pipe[2];
                link.ctl_dq_oe_n <= rd_pipe[1] || rd_pipe[2];
                link.ctl_dq_out  <= wr_pipe[1] ? wdata_d : '0;
                if (rd_pipe[2]) begin
                    rd_data  <= link.dq_in;
                    rd_valid <= 1'b1;
                end
            end
        end
    end
endmodule : ddr_ctl_end

// ---- verification/ddr_turn_asserts.sv ----
// Turnaround checks on the link between the two ends
`timescale 1ns/10ps
module ddr_turn_asserts #(
    parameter int DATA_W = 18
) (
    input wire logic              link_clk,
    input wire logic              rst_b,
    input wire logic              load_select_n,
    input wire logic              rw_select,
    input wire logic              ctl_dq_oe_n,
    input wire logic              ctl_term_en,
    input wire logic [DATA_W-1:0] mem_dq_out,
    input wire logic              mem_dq_oe_n,
    input wire logic              mem_term_en
);
    // ****
    // Decode and settle guard
    // ****
    logic [2:0] up;
    wire        rd  = !load_select_n && rw_select;
    wire        wr  = !load_select_n && !rw_select;
    wire        low = !mem_dq_oe_n && !mem_term_en && mem_dq_out == '0;
    wire        ok  = up[2];
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) up <= 3'h0;
        else if (!up[2]) up <= up + 3'h1;
    end
    default clocking @(posedge link_clk); endclocking
    default disable iff (!rst_b);
    a_no_write_after_read:
        assert property (rd |=> rw_select) else $error("write side right after read");
    a_ridle_after_read:
        assert property (rd ##1 !rd |-> rw_select [*2]) else $error("too few read idles");
    a_widle_before_write:
        assert property (ok && $fell(rw_select) |-> (load_select_n && !rw_select) [*3])
        else $error("too few write idles");
    a_term_on_wsel:
        assert property (ok && !$past(rw_select, 2) && !$past(rd, 3) |-> mem_term_en && mem_dq_oe_n)
        else $error("pins not terminated");
    a_low_on_rsel:
        assert property (ok && $past(rw_select, 2) && !$past(rd, 3) |-> low) else $error("pins not driven low");
    a_read_data_lat:
        assert property (ok && $past(rd, 3) && $past(rw_select, 2) |-> !mem_dq_oe_n && !mem_term_en)
        else $error("read data not driven");
    a_low_before_read:
        assert property (ok && rd && !$past(rd) |-> ##2 low ##1 !mem_dq_oe_n) else $error("no low cycle before data");
    a_term_off_write:
        assert property (wr ##1 rw_select |-> ##2 !mem_term_en) else $error("termination kept after write");
    a_ctl_quiet:
        assert property (ctl_term_en == ctl_dq_oe_n) else $error("controller floats or fights");
    c_rd_rd: cover property (rd ##1 rd);
    c_wr_rd: cover property (wr ##1 rd);
    c_rd_wr: cover property (rd ##1 !rd ##[1:12] wr);
endmodule : ddr_turn_asserts

// ---- verification/ddr_sram_dq_turnaround_test.sv ----
// Self-checking bench joining controller and memory ends
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module ddr_sram_dq_turnaround_test;
    localparam int DATA_W = 18;
    logic              ref_clk    = 1'b0;
    logic              rst_b      = 1'b0;
    logic              req_valid  = 1'b0;
    logic              req_write  = 1'b0;
    logic              tog        = 1'b0;
    logic [DATA_W-1:0] req_data   = '0;
    logic [DATA_W-1:0] array_word = '0;
    logic [DATA_W-1:0] last_w     = '0;
    logic [DATA_W-1:0] exp_w, wr_data, ctl_rd_data;
    logic              wr_strobe, rd_request, req_ready, rd_valid;
    logic [15:0]       lfsr       = 16'h97e3;
    logic [DATA_W-1:0] wq[$];
    int                n_fail = 0, total_checks = 0, n_rd = 0, n_val = 0, n_iss = 0;
    ddr_turn_if #(.DATA_W(DATA_W)) link ();
    // Released bus toggles, contention goes unknown
    assign link.dq_in = (!link.mem_dq_oe_n && !link.ctl_dq_oe_n) ? 'x : !link.mem_dq_oe_n ? link.mem_dq_out :
                        !link.ctl_dq_oe_n ? link.ctl_dq_out : {9{tog, !tog}};
    always #5 ref_clk = !ref_clk;
    always @(posedge ref_clk) tog <= !tog;
    ddr_mem_end #(.DATA_W(DATA_W)) ddr_mem_end_i (.link(link.mem), .ref_clk(ref_clk), .rst_b(rst_b),
        .rd_data(array_word), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_request(rd_request));
    ddr_ctl_end #(.DATA_W(DATA_W)) ddr_ctl_end_i (.link(link.ctl), .ref_clk(ref_clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_data(req_data), .req_ready(req_ready),
        .rd_data(ctl_rd_data), .rd_valid(rd_valid));
    ddr_turn_asserts #(.DATA_W(DATA_W)) ddr_turn_asserts_i (.link_clk(link.link_clk), .rst_b(rst_b),
        .load_select_n(link.load_select_n), .rw_select(link.rw_select), .ctl_dq_oe_n(link.ctl_dq_oe_n),
        .ctl_term_en(link.ctl_term_en), .mem_dq_out(link.mem_dq_out), .mem_dq_oe_n(link.mem_dq_oe_n),
        .mem_term_en(link.mem_term_en));
    // ****
    // Array and scoreboard model
    // ****
    always @(posedge ref_clk) begin
        if (wr_strobe === 1'b1) begin
            exp_w = wq.pop_front();
            `CHK("wr_data", exp_w, wr_data)
            array_word <= wr_data;
        end
        if (rd_request === 1'b1) n_rd++;
        if (rd_valid === 1'b1) begin
            n_val++;
            `CHK("rd_data", last_w, ctl_rd_data)
        end
    end
    function automatic logic [15:0] next_lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : next_lfsr
    task automatic issue(input logic wr, input logic [DATA_W-1:0] d);
        int i;
        req_valid = 1'b1;
        req_write = wr;
        req_data = d;
        i = 0;
        do begin @(posedge ref_clk); i++; end while (req_ready !== 1'b1 && i < 400);
        `CHK("req_ready", 1'b1, req_ready)
        #1;
        if (wr) begin wq.push_back(d); last_w = d; end
        else n_iss++;
    endtask : issue
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // ****
    // Main sequence and watchdog
    // ****
    initial begin
        int k, n;
        logic same;
        repeat (20) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        for (k = 0; k < 10; k++) begin
            n = 1 + lfsr[1:0] % 3;
            same = lfsr[3];
            lfsr = next_lfsr(lfsr);
            // Repeating the stored word lets reads follow writes at once
            repeat (n) begin
                issue(1'b1, same ? last_w : {lfsr[1:0], lfsr});
                lfsr = next_lfsr(lfsr);
            end
            if (!same) begin req_valid = 1'b0; repeat (60) @(posedge ref_clk); #1; end
            repeat (n) issue(1'b0, '0);
            req_valid = 1'b0;
        end
        repeat (80) @(posedge ref_clk);
        `CHK("rd_request count", n_iss, n_rd)
        `CHK("rd_valid count", n_iss, n_val)
        finish_test;
    end
    initial begin
        #500000;
        n_fail++;
        finish_test;
    end
endmodule : ddr_sram_dq_turnaround_test
